//--- design/can_remote_timer_mgmt.sv
// Mailbox remote-frame handling, CPU access arbitration and timer management
`timescale 1ns/10ps
`include "can_rt_consts.svh"
// Function
// - Sent remote request leaves transmit-acknowledge clear, no interrupt; reply received normally.
// - Remote frame identifier compared through masks, highest mailbox downward.
// - Match on auto-answer send mailbox sets its transmit request.
// - Send mailbox without auto-answer ignores it; any send match stops search.
// - Match on receive mailbox stores frame like data and sets pending.
// - Selected mailbox withheld while change request set; pending request resumes after.
// - Identifier writes accepted only while mailbox is disabled.
// - Receive mailbox with remote bit sends request, stores answer itself.
// - Direction, auto-answer, remote bits decode transmit, receive, request, reply.
// - Data writes blocked for enabled receive mailboxes.
// - Enabled send mailbox data writes denied while set or reset request pending, unless change request selects it.
// - Change request checked before and after reading; blocked mailbox skipped.
// - Change request suppresses write-denied flag for selected mailbox.
// - Deadline scanner yields register access to protocol engine.
// - Readable writable 32-bit tick counter copied into stamps on store or send.
// - Counter advances on bit clock, halts in init, sleep, suspend; reset clears.
// - Writing one to msb-clear clears only the counter top bit.
// - With autoclear, mailbox 16 success clears counter, direction from its bit.
// - Counter top bit rising sets the overflow flag.
// - Scanner sets deadline status when counter reaches deadline and conditions hold.
// - Transmit status clears with enable or request; receive only with enable.
// - Writing one clears a deadline status bit, zero leaves it.
// - Soft reset defaults all state except bit timing, kept control, pin functions, mailbox memory.
// - Soft reset keeps mailbox memory, cancels transmissions cleanly.
module can_remote_timer_mgmt (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic [10:0]            addr,
    input  wire logic [31:0]            wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output wire logic [31:0]            rdata,
    input  wire logic                   bit_tick,
    input  wire logic                   init_mode,
    input  wire logic                   sleep_mode,
    input  wire logic                   suspend_mode,
    input  wire logic                   rx_valid,
    input  wire can_rt_pkg::can_frame_t rx_frame,
    input  wire logic                   tx_start,
    input  wire logic                   tx_done,
    input  wire logic                   tx_ok,
    output wire logic                   tx_valid,
    output wire logic [4:0]             tx_mbox,
    output wire can_rt_pkg::can_frame_t tx_frame,
    output wire logic                   tx_cancel
);

    can_rt_pkg::state_t s;
    can_rt_pkg::state_t n;
    logic [4:0]         mb;
    logic [2:0]         fld;
    logic [4:0]         hit;
    logic [4:0]         pick;
    logic [4:0]         cur;
    logic               found;
    logic               got;
    logic               clr;
    logic               soft_reset_cmd;
    logic               deny;
    logic               busy;
    logic [31:0]        tos_set;

    function automatic logic id_match(input logic [28:0] a,
                                      input logic [28:0] b,
                                      input logic [28:0] m);
        id_match = ((a ^ b) & m) == 29'h0;
    endfunction

    function automatic logic cdr_blk(input can_rt_pkg::state_t st,
                                     input logic [4:0] i);
        cdr_blk = st.mc[`RT_MC_CDR] && (st.mc[`RT_MC_SEL_HI:`RT_MC_SEL_LO] == i);
    endfunction

    assign rdata     = s.rdata;
    assign tx_valid  = s.tx_valid;
    assign tx_mbox   = s.tx_mbox;
    assign tx_frame  = s.tx_frame;
    assign tx_cancel = s.tx_cancel;

    always_comb begin
        n       = s;
        mb      = addr[9:5];
        fld     = addr[4:2];
        hit     = 5'h0;
        pick    = 5'h0;
        cur     = s.tx_cur;
        found   = 1'b0;
        got     = 1'b0;
        clr     = 1'b0;
        soft_reset_cmd    = 1'b0;
        deny    = 1'b0;
        tos_set = 32'h0;
        // Protocol engine traffic owns the register port this cycle
        busy    = rx_valid || tx_start || tx_done;

        n.tx_cancel = 1'b0;
        n.rdata     = 32'h0;

        if (bit_tick && !init_mode && !sleep_mode && !suspend_mode) begin
            n.ticks = s.ticks + 32'h1;
        end

        // CPU register and mailbox writes
        if (wr) begin
            if (addr[`RT_MBOX_BIT]) begin
                unique case (fld)
                    `RT_FLD_ID: begin
                        if (!s.me[mb]) begin
                            n.id[mb] = wdata[29:0];
                        end else begin
                            deny = 1'b1;
                        end
                    end
                    `RT_FLD_CTRL: begin
                        if (!s.me[mb]) begin
                            n.ctrl[mb] = wdata[4:0];
                        end else begin
                            deny = 1'b1;
                        end
                    end
                    `RT_FLD_DLO, `RT_FLD_DHI: begin
                        if (s.me[mb] && s.md[mb]) begin
                            deny = 1'b1;
                        end else if (s.me[mb] && (s.tx_request_set[mb] || s.tx_request_reset[mb])
                                     && !cdr_blk(s, mb)) begin
                            deny = 1'b1;
                        end else if (fld == `RT_FLD_DLO) begin
                            n.data[mb][31:0] = wdata;
                        end else begin
                            n.data[mb][63:32] = wdata;
                        end
                    end
                    `RT_FLD_MASK:  n.mask[mb] = wdata[28:0];
                    `RT_FLD_STAMP: n.stamp[mb] = wdata;
                    `RT_FLD_DL:    n.dl[mb] = wdata;
                    default: ;
                endcase
                if (deny && !cdr_blk(s, mb)) begin
                    n.gif[`RT_GIF_WDI] = 1'b1;
                end
            end else begin
                unique case (addr)
                    `RT_OFF_MC: begin
                        soft_reset_cmd = wdata[`RT_MC_SOFT_RESET_CMD];
                        n.mc = wdata & `RT_MC_WMASK;
                        if (wdata[`RT_MC_MSBCLR]) begin
                            n.ticks[31] = 1'b0;
                        end
                    end
                    `RT_OFF_ME:    n.me = wdata;
                    `RT_OFF_MD:    n.md = wdata;
                    `RT_OFF_TRS:   n.tx_request_set = s.tx_request_set | wdata;
                    `RT_OFF_TRR:   n.tx_request_reset = s.tx_request_reset | wdata;
                    `RT_OFF_TA:    n.ta = s.ta & ~wdata;
                    `RT_OFF_RMP:   n.rx_pending = s.rx_pending & ~wdata;
                    `RT_OFF_TOC:   n.deadline_enable = wdata;
                    `RT_OFF_TOS:   n.deadline_status = s.deadline_status & ~wdata;
                    `RT_OFF_GIF:   n.gif = s.gif & ~wdata[1:0];
                    `RT_OFF_TICKS: n.ticks = wdata;
                    `RT_OFF_BTC:   n.btc = wdata;
                    `RT_OFF_PINF:  n.pinf = wdata[1:0];
                    default: ;
                endcase
            end
        end

        // Idle mailboxes abort at once; the active one waits for its frame end
        for (int i = 0; i < 32; i++) begin
            if (s.tx_request_reset[i] && !(s.tx_act && s.tx_cur == 5'(i))) begin
                n.tx_request_set[i] = 1'b0;
                n.tx_request_reset[i] = 1'b0;
            end
        end

        // Check again at the moment the engine reads the mailbox
        if (tx_start && s.tx_valid && !cdr_blk(s, s.tx_mbox)) begin
            n.tx_act = 1'b1;
            n.tx_cur = s.tx_mbox;
        end

        if (tx_done && s.tx_act) begin
            n.tx_act = 1'b0;
            if (tx_ok) begin
                n.tx_request_set[cur] = 1'b0;
                n.tx_request_reset[cur] = 1'b0;
                // A request object only sent a remote frame
                if (!(s.md[cur] && s.ctrl[cur][`RT_CTRL_RTR])) begin
                    n.ta[cur] = 1'b1;
                end
                n.stamp[cur] = s.ticks;
                if (cur == `RT_ACLR_MBOX && !s.md[cur]) begin
                    clr = s.mc[`RT_MC_ACLR];
                end
            end else if (s.tx_request_reset[cur]) begin
                n.tx_request_set[cur] = 1'b0;
                n.tx_request_reset[cur] = 1'b0;
            end
        end

        // Receive match, highest mailbox first
        for (int i = 31; i >= 0; i--) begin
            if (!found && s.me[i] && (rx_frame.rtr || s.md[i])
                && id_match(rx_frame.id, s.id[i][28:0], s.mask[i])) begin
                found = 1'b1;
                hit   = 5'(i);
            end
        end

        if (rx_valid && found) begin
            if (!s.md[hit]) begin
                // Send mailbox: search ends here, stored never
                if (s.id[hit][`RT_ID_AA]) begin
                    n.tx_request_set[hit] = 1'b1;
                end
            end else begin
                n.id[hit][28:0] = rx_frame.id;
                n.ctrl[hit]     = {rx_frame.rtr, rx_frame.dlc};
                n.data[hit]     = rx_frame.data;
                n.rx_pending[hit]      = 1'b1;
                n.stamp[hit]    = s.ticks;
                if (hit == `RT_ACLR_MBOX) begin
                    clr = s.mc[`RT_MC_ACLR];
                end
            end
        end

        if (clr) begin
            n.ticks = 32'h0;
        end

        if (!s.ticks[31] && n.ticks[31]) begin
            n.gif[`RT_GIF_OVF] = 1'b1;
        end

        // One deadline compare per free slot keeps the scan off the engine path
        if (!busy) begin
            if (s.deadline_enable[s.scan] && (s.ticks >= s.dl[s.scan])
                && (s.md[s.scan] || s.tx_request_set[s.scan])) begin
                tos_set[s.scan] = 1'b1;
            end
            n.scan = s.scan + 5'h1;
        end

        n.deadline_status = (n.deadline_status | tos_set) & n.deadline_enable & (n.md | n.tx_request_set);

        if (soft_reset_cmd) begin
            n.mc        = s.mc & `RT_MC_KEEP;
            n.me        = 32'h0;
            n.md        = 32'h0;
            n.tx_request_set       = 32'h0;
            n.tx_request_reset       = 32'h0;
            n.ta        = 32'h0;
            n.rx_pending       = 32'h0;
            n.deadline_enable       = 32'h0;
            n.deadline_status       = 32'h0;
            n.gif       = 2'h0;
            n.ticks     = 32'h0;
            n.scan      = 5'h0;
            n.tx_act    = 1'b0;
            n.tx_cancel = 1'b1;
        end

        // Next candidate: enabled, requested, not aborting, not under update
        for (int i = 31; i >= 0; i--) begin
            if (!got && n.me[i] && n.tx_request_set[i] && !n.tx_request_reset[i]
                && !cdr_blk(n, 5'(i))) begin
                got  = 1'b1;
                pick = 5'(i);
            end
        end
        // Transmit or reply sends data; request sends a remote frame
        n.tx_valid      = got && !n.tx_act;
        n.tx_mbox       = pick;
        n.tx_frame.id   = n.id[pick][28:0];
        n.tx_frame.rtr  = n.md[pick] && n.ctrl[pick][`RT_CTRL_RTR];
        n.tx_frame.dlc  = n.ctrl[pick][3:0];
        n.tx_frame.data = n.data[pick];

        if (rd) begin
            if (addr[`RT_MBOX_BIT]) begin
                unique case (fld)
                    `RT_FLD_ID:    n.rdata = {2'h0, s.id[mb]};
                    `RT_FLD_CTRL:  n.rdata = {27'h0, s.ctrl[mb]};
                    `RT_FLD_DLO:   n.rdata = s.data[mb][31:0];
                    `RT_FLD_DHI:   n.rdata = s.data[mb][63:32];
                    `RT_FLD_MASK:  n.rdata = {3'h0, s.mask[mb]};
                    `RT_FLD_STAMP: n.rdata = s.stamp[mb];
                    `RT_FLD_DL:    n.rdata = s.dl[mb];
                    default:       n.rdata = 32'h0;
                endcase
            end else begin
                unique case (addr)
                    `RT_OFF_MC:    n.rdata = s.mc;
                    `RT_OFF_ME:    n.rdata = s.me;
                    `RT_OFF_MD:    n.rdata = s.md;
                    `RT_OFF_TRS:   n.rdata = s.tx_request_set;
                    `RT_OFF_TRR:   n.rdata = s.tx_request_reset;
                    `RT_OFF_TA:    n.rdata = s.ta;
                    `RT_OFF_RMP:   n.rdata = s.rx_pending;
                    `RT_OFF_TOC:   n.rdata = s.deadline_enable;
                    `RT_OFF_TOS:   n.rdata = s.deadline_status;
                    `RT_OFF_GIF:   n.rdata = {30'h0, s.gif};
                    `RT_OFF_TICKS: n.rdata = s.ticks;
                    `RT_OFF_BTC:   n.rdata = s.btc;
                    `RT_OFF_PINF:  n.rdata = {30'h0, s.pinf};
                    default:       n.rdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s      <= '0;
            s.mc   <= `RT_MC_RST;
        end else begin
            s <= n;
        end
    end

endmodule

//--- common/can_rt_consts.svh
// Offsets, field positions and reset values of the remote-frame and timer block
`ifndef CAN_RT_CONSTS_SVH
`define CAN_RT_CONSTS_SVH
`define RT_OFF_MC    11'h000
`define RT_OFF_ME    11'h004
`define RT_OFF_MD    11'h008
`define RT_OFF_TRS   11'h00C
`define RT_OFF_TRR   11'h010
`define RT_OFF_TA    11'h014
`define RT_OFF_RMP   11'h018
`define RT_OFF_TOC   11'h01C
`define RT_OFF_TOS   11'h020
`define RT_OFF_GIF   11'h024
`define RT_OFF_TICKS 11'h028
`define RT_OFF_BTC   11'h02C
`define RT_OFF_PINF  11'h030
`define RT_MBOX_BIT  10
`define RT_FLD_ID    3'h0
`define RT_FLD_CTRL  3'h1
`define RT_FLD_DLO   3'h2
`define RT_FLD_DHI   3'h3
`define RT_FLD_MASK  3'h4
`define RT_FLD_STAMP 3'h5
`define RT_FLD_DL    3'h6
`define RT_MC_SOFT_RESET_CMD   0
`define RT_MC_CDR    1
`define RT_MC_SEL_LO 2
`define RT_MC_SEL_HI 6
`define RT_MC_MSBCLR 7
`define RT_MC_ACLR   8
// Bits 8..15: autoclear, compat, cfg change, powerdown, byte order, wake, busoff, loop
`define RT_MC_KEEP   32'h0000FF00
`define RT_MC_WMASK  32'h0000FF7E
`define RT_MC_RST    32'h00000400
`define RT_GIF_OVF   0
`define RT_GIF_WDI   1
`define RT_ID_AA     29
`define RT_CTRL_RTR  4
`define RT_ACLR_MBOX 5'h10
`endif

//--- common/can_rt_pkg.sv
// Types of the remote-frame and timer block
package can_rt_pkg;
    typedef struct packed {
        logic [28:0] id;
        logic        rtr;
        logic [3:0]  dlc;
        logic [63:0] data;
    } can_frame_t;

    typedef struct packed {
        logic [31:0]       mc;
        logic [31:0]       btc;
        logic [1:0]        pinf;
        logic [31:0]       me;
        logic [31:0]       md;
        logic [31:0]       tx_request_set;
        logic [31:0]       tx_request_reset;
        logic [31:0]       ta;
        logic [31:0]       rx_pending;
        logic [31:0]       deadline_enable;
        logic [31:0]       deadline_status;
        logic [1:0]        gif;
        logic [31:0]       ticks;
        logic [31:0][29:0] id;
        logic [31:0][28:0] mask;
        logic [31:0][4:0]  ctrl;
        logic [31:0][63:0] data;
        logic [31:0][31:0] stamp;
        logic [31:0][31:0] dl;
        logic [4:0]        scan;
        logic              tx_act;
        logic [4:0]        tx_cur;
        logic [31:0]       rdata;
        logic              tx_valid;
        logic [4:0]        tx_mbox;
        can_frame_t        tx_frame;
        logic              tx_cancel;
    } state_t;
endpackage

//--- tb/can_rt_properties.sv
// Port assertions for the remote-frame and timer block
`timescale 1ns/10ps
`include "can_rt_consts.svh"
module can_rt_properties (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [10:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        rx_valid,
    input wire logic        tx_start,
    input wire logic        tx_done,
    input wire logic        tx_ok,
    input wire logic        tx_valid,
    input wire logic [4:0]  tx_mbox,
    input wire logic        tx_cancel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic soft_reset_cmd;
    logic calm;
    assign soft_reset_cmd = wr && addr == `RT_OFF_MC && wdata[`RT_MC_SOFT_RESET_CMD];
    // Only these events may move the transmit candidate
    assign calm = !(wr || rx_valid || tx_done);
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside read slot");
    cancel_start_a: assert property (soft_reset_cmd |=> tx_cancel)
        else $error("no cancel after soft reset");
    cancel_once_a: assert property (tx_cancel |=> !tx_cancel)
        else $error("cancel longer than one cycle");
    cancel_cause_a: assert property (tx_cancel |-> $past(soft_reset_cmd))
        else $error("cancel without soft reset");
    soft_reset_cmd_quiet_a: assert property (soft_reset_cmd |=> !tx_valid)
        else $error("transmit request kept over soft reset");
    valid_rise_a: assert property ($rose(tx_valid) |-> $past(!calm))
        else $error("transmit request without cause");
    valid_fall_a: assert property ($fell(tx_valid) |->
        $past(tx_start || wr) || $past(wr, 2)) else $error("transmit request lost");
    mbox_hold_a: assert property (tx_valid && $stable(tx_valid) && $past(calm)
        && $past(calm, 2) |-> $stable(tx_mbox)) else $error("candidate moved");
    rx_seen_c: cover property (rx_valid);
    tx_good_c: cover property (tx_done && tx_ok);
    soft_reset_cmd_c: cover property (soft_reset_cmd ##1 tx_cancel);
endmodule
bind can_remote_timer_mgmt can_rt_properties i_props (.*);

//--- tb/can_node_model.sv
// Far-side CAN node: takes queued frames after a latency, injects frames
`timescale 1ns/10ps
module can_node_model (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   tx_valid,
    input  wire logic [3:0]             lat,
    input  wire logic                   ok_sel,
    input  wire logic                   inj,
    input  wire can_rt_pkg::can_frame_t inj_frame,
    output logic                        rx_valid,
    output can_rt_pkg::can_frame_t      rx_frame,
    output logic                        tx_start,
    output logic                        tx_done,
    output logic                        tx_ok
);
    int cnt;
    always @(posedge core_clk) begin
        rx_valid <= inj;
        // No stale copy between frames, so a late read shows up
        rx_frame <= inj ? inj_frame : ~rx_frame;
        tx_start <= 1'b0;
        tx_done <= 1'b0;
        tx_ok <= ~tx_ok;
        if (rst) begin
            cnt <= 0;
            rx_frame <= '0;
            tx_ok <= 1'b0;
        end else if (cnt == 0 && tx_valid && !tx_start) begin
            tx_start <= 1'b1;
            cnt <= 1;
        end else if (cnt == 1) begin
            cnt <= 2;
        end else if (cnt == 2 && tx_valid) begin
            cnt <= 0;
        end else if (cnt == 2) begin
            cnt <= 4 + lat;
        end else if (cnt == 3) begin
            tx_done <= 1'b1;
            tx_ok <= ok_sel;
            cnt <= 0;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

//--- tb/can_remote_timer_mgmt_test.sv
// Self-checking bench for the remote-frame and timer block
`timescale 1ns/10ps
`include "can_rt_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module can_remote_timer_mgmt_test;
    logic                   core_clk, rst, wr, rd, bit_tick, inj, ok_sel, last_r;
    logic                   rx_valid, tx_start, tx_done, tx_ok, tx_valid, tx_cancel;
    logic [10:0]            addr;
    logic [31:0]            wdata, rdata;
    logic [2:0]             modes;
    logic [3:0]             lat;
    logic [4:0]             tx_mbox, last_m;
    logic [63:0]            d;
    logic [28:0]            id;
    can_rt_pkg::can_frame_t rx_frame, tx_frame, inj_frame;
    int                     errors, checks_done, n;
    can_remote_timer_mgmt i_dut (.*, .init_mode(modes[0]), .sleep_mode(modes[1]),
        .suspend_mode(modes[2]));
    can_node_model i_node (.*);
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (tx_start && tx_valid) begin
        last_m <= tx_mbox;
        last_r <= tx_frame.rtr;
    end
    function automatic logic [10:0] mb(input int k, input int f);
        return 11'(1024 + k * 32 + f * 4);
    endfunction
    task automatic tally_and_finish();
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wrr(input logic [10:0] a, input logic [31:0] v);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [10:0] a, input logic [31:0] e);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic ticks(input int k);
        @(posedge core_clk);
        bit_tick <= 1'b1;
        repeat (k) @(posedge core_clk);
        bit_tick <= 1'b0;
    endtask
    task automatic inj_f(input logic [28:0] fid, input logic r, input logic [63:0] fd);
        @(posedge core_clk);
        inj <= 1'b1;
        inj_frame <= '{fid, r, 4'h8, fd};
        @(posedge core_clk);
        inj <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic sent(input logic [4:0] m, input logic r);
        int i;
        for (i = 0; i < 80 && tx_done !== 1'b1; i++)
            @(posedge core_clk);
        if (i == 80) begin
            errors++;
            tally_and_finish();
        end
        repeat (2) @(posedge core_clk);
        `CHK({last_m, last_r}, {m, r})
    endtask
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        {addr, wdata, wr, rd, bit_tick, modes, inj, inj_frame, lat} = '0;
        ok_sel = 1'b1;
        errors = 0;
        checks_done = 0;
        n = $urandom(92);
        d = {$urandom, $urandom};
        id = 29'($urandom);
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdc(`RT_OFF_MC, 32'h00000400);
        rdc(11'h034, 32'h0);
        for (int i = 0; i < 3; i++) begin
            modes <= 3'(1 << i);
            ticks(3);
        end
        modes <= 3'h0;
        n = $urandom_range(30, 5);
        ticks(n);
        rdc(`RT_OFF_TICKS, 32'(n));
        wrr(`RT_OFF_TICKS, 32'h7FFFFFFF);
        ticks(1);
        rdc(`RT_OFF_GIF, 32'h1);
        wrr(`RT_OFF_MC, 32'h00000480);
        rdc(`RT_OFF_TICKS, 32'h0);
        wrr(`RT_OFF_GIF, 32'h3);
        for (int k = 10; k < 26; k++) begin
            wrr(mb(k, 4), 32'h1FFFFFFF);
        end
        wrr(mb(16, 0), {3'h0, id});
        wrr(mb(20, 0), {3'h1, ~id});
        wrr(mb(25, 0), {3'h0, ~id});
        wrr(mb(10, 0), {3'h0, id ^ 29'h1});
        wrr(mb(10, 1), 32'h00000018);
        wrr(`RT_OFF_MD, 32'h00010400);
        wrr(`RT_OFF_ME, 32'h02110400);
        wrr(`RT_OFF_MC, 32'h00000500);
        ticks(5);
        inj_f(id, 1'b0, d);
        rdc(`RT_OFF_RMP, 32'h00010000);
        rdc(mb(16, 3), d[63:32]);
        rdc(mb(16, 5), 32'h5);
        rdc(`RT_OFF_TICKS, 32'h0);
        wrr(mb(16, 2), ~d[31:0]);
        rdc(mb(16, 2), d[31:0]);
        rdc(`RT_OFF_GIF, 32'h2);
        wrr(mb(16, 0), 32'h0);
        rdc(mb(16, 0), {3'h0, id});
        wrr(`RT_OFF_RMP, 32'hFFFFFFFF);
        inj_f(id, 1'b1, d);
        rdc(`RT_OFF_RMP, 32'h00010000);
        inj_f(~id, 1'b1, d);
        rdc(`RT_OFF_TRS, 32'h0);
        rdc(`RT_OFF_RMP, 32'h00010000);
        wrr(`RT_OFF_ME, 32'h00110400);
        inj_f(~id, 1'b1, d);
        sent(5'd20, 1'b0);
        rdc(`RT_OFF_TA, 32'h00100000);
        wrr(`RT_OFF_GIF, 32'h3);
        wrr(`RT_OFF_MC, 32'h00000452);
        wrr(`RT_OFF_TRS, 32'h00100000);
        repeat (8) @(posedge core_clk);
        rdc(`RT_OFF_TRS, 32'h00100000);
        wrr(mb(20, 2), ~d[31:0]);
        rdc(`RT_OFF_GIF, 32'h0);
        wrr(`RT_OFF_MC, 32'h00000400);
        sent(5'd20, 1'b0);
        rdc(mb(20, 2), ~d[31:0]);
        lat <= 4'hF;
        wrr(`RT_OFF_TRS, 32'h00100000);
        wrr(mb(20, 3), 32'hFFFFFFFF);
        rdc(`RT_OFF_GIF, 32'h2);
        rdc(mb(20, 3), 32'h0);
        sent(5'd20, 1'b0);
        wrr(`RT_OFF_TA, 32'hFFFFFFFF);
        wrr(`RT_OFF_RMP, 32'hFFFFFFFF);
        wrr(`RT_OFF_TRS, 32'h00000400);
        sent(5'd10, 1'b1);
        rdc(`RT_OFF_TA, 32'h0);
        inj_f(id ^ 29'h1, 1'b0, ~d);
        rdc(`RT_OFF_RMP, 32'h00000400);
        rdc(mb(10, 3), ~d[63:32]);
        wrr(`RT_OFF_TOC, 32'h00000400);
        repeat (40) @(posedge core_clk);
        rdc(`RT_OFF_TOS, 32'h00000400);
        wrr(`RT_OFF_TOS, 32'h0);
        rdc(`RT_OFF_TOS, 32'h00000400);
        wrr(`RT_OFF_TOC, 32'h0);
        rdc(`RT_OFF_TOS, 32'h0);
        wrr(`RT_OFF_MC, 32'h00000500);
        wrr(`RT_OFF_MC, 32'h00000501);
        rdc(`RT_OFF_MC, 32'h00000500);
        rdc(`RT_OFF_ME, 32'h0);
        rdc(mb(10, 3), ~d[63:32]);
        tally_and_finish();
    end
endmodule
